// ==== logic/aer_pkg.sv ====
// Constants, types and decode helpers for the uncorrectable error register block
package aer_pkg;

  localparam int          AER_AW        = 12;
  localparam int          AER_DW        = 32;
  localparam int          AER_BEW       = AER_DW / 8;

  localparam logic [11:0] AER_HDR_OFF   = 12'h100;
  localparam logic [11:0] AER_STAT_OFF  = 12'h104;
  localparam logic [11:0] AER_MASK_OFF  = 12'h108;

  localparam logic [15:0] AER_CAP_ID    = 16'h0001;
  localparam logic [3:0]  AER_CAP_VER   = 4'h1;
  localparam logic [11:0] AER_NEXT_PTR  = 12'h000;

  // Implemented bits of status and mask; everything else is reserved
  localparam logic [31:0] AER_IMPL      = 32'h001FF011;
  localparam logic [31:0] AER_STAT_RST  = 32'h00000000;
  localparam logic [31:0] AER_MASK_RST  = 32'h00000000;

  localparam int AER_B_TRAIN   = 0;
  localparam int AER_B_DLP     = 4;
  localparam int AER_B_POISON  = 12;
  localparam int AER_B_FCP     = 13;
  localparam int AER_B_CPL_TO  = 14;
  localparam int AER_B_CPL_AB  = 15;
  localparam int AER_B_UNEXP   = 16;
  localparam int AER_B_RX_OVF  = 17;
  localparam int AER_B_MALF    = 18;
  localparam int AER_B_ECRC    = 19;
  localparam int AER_B_UNSUP   = 20;

  typedef struct packed {
    logic                valid;
    logic                write;
    logic [AER_AW-1:0]   addr;
    logic [AER_BEW-1:0]  be;
    logic [AER_DW-1:0]   data;
  } aer_cfg_req_s;

  typedef struct packed {
    logic                valid;
    logic [AER_DW-1:0]   data;
  } aer_cfg_rsp_s;

  typedef struct packed {
    logic unsup_req;
    logic ecrc;
    logic malformed;
    logic rx_overflow;
    logic unexp_cpl;
    logic cpl_abort;
    logic cpl_timeout;
    logic fc_protocol;
    logic poisoned;
    logic dl_protocol;
    logic training;
  } aer_evt_s;

  // Place each event at its status bit position
  function automatic logic [31:0] aer_evt_vec(input aer_evt_s e);
    logic [31:0] v;
    v               = 32'h00000000;
    v[AER_B_TRAIN]  = e.training;
    v[AER_B_DLP]    = e.dl_protocol;
    v[AER_B_POISON] = e.poisoned;
    v[AER_B_FCP]    = e.fc_protocol;
    v[AER_B_CPL_TO] = e.cpl_timeout;
    v[AER_B_CPL_AB] = e.cpl_abort;
    v[AER_B_UNEXP]  = e.unexp_cpl;
    v[AER_B_RX_OVF] = e.rx_overflow;
    v[AER_B_MALF]   = e.malformed;
    v[AER_B_ECRC]   = e.ecrc;
    v[AER_B_UNSUP]  = e.unsup_req;
    return v;
  endfunction

  // Byte enables widened to a bit mask
  function automatic logic [31:0] aer_be_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

endpackage

// ==== logic/aer_w1c_bank.sv ====
// Sticky write-one-to-clear status bits
`timescale 1ns/1ns
`default_nettype none
module aer_w1c_bank #(
  parameter int          W    = 32,
  parameter logic [31:0] IMPL = aer_pkg::AER_IMPL
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set_vec,
  input  wire logic [W-1:0] clr_vec,
  output var  logic [W-1:0] q_ff
);
  import aer_pkg::*;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      if (IMPL[i]) begin : g_impl
        logic nxt_q;
        // Set beats clear so no event is lost in the clearing cycle
        assign nxt_q = set_vec[i] | (q_ff[i] & ~clr_vec[i]);
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            q_ff[i] <= AER_STAT_RST[i];
          end else begin
            q_ff[i] <= nxt_q;
          end
        end
      end else begin : g_rsvd
        assign q_ff[i] = 1'b0;
      end
    end
  endgenerate

endmodule // aer_w1c_bank
`default_nettype wire

// ==== logic/aer_evt_gate.sv ====
// Mask gating of error events onto header-log and message requests
`timescale 1ns/1ns
`default_nettype none
module aer_evt_gate #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] evt_vec,
  input  wire logic [W-1:0] mask,
  output logic      [W-1:0] log_ff,
  output logic              msg_ff
);
  import aer_pkg::*;

  logic [W-1:0] nxt_log;
  logic         nxt_msg;

  assign nxt_log = evt_vec & ~mask;
  assign nxt_msg = |nxt_log;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      log_ff <= '0;
      msg_ff <= 1'b0;
    end else begin
      log_ff <= nxt_log;
      msg_ff <= nxt_msg;
    end
  end

endmodule // aer_evt_gate
`default_nettype wire

// ==== logic/aer_regs.sv ====
// Uncorrectable error reporting registers reached through configuration space
`timescale 1ns/1ns
`default_nettype none
module aer_regs (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire aer_pkg::aer_cfg_req_s cfg_req,
  output aer_pkg::aer_cfg_rsp_s      cfg_rsp_ff,
  input  wire aer_pkg::aer_evt_s     err_evt,
  output logic [31:0]                hdr_log_req_ff,
  output logic                       err_msg_req_ff,
  output logic [31:0]                stat_out_ff
);
  import aer_pkg::*;

  logic [31:0]  status;
  logic [31:0]  mask_ff;
  logic [31:0]  nxt_mask;
  logic [31:0]  evt_vec;
  logic [31:0]  wr_bits;
  logic [31:0]  stat_clr;
  logic [31:0]  hdr_word;
  logic [31:0]  rd_data;
  logic         hit_hdr;
  logic         hit_stat;
  logic         hit_mask;
  logic         wr_stat;
  logic         wr_mask;
  aer_cfg_rsp_s nxt_rsp;

  assign evt_vec  = aer_evt_vec(err_evt) & AER_IMPL;
  assign hit_hdr  = cfg_req.addr == AER_HDR_OFF;
  assign hit_stat = cfg_req.addr == AER_STAT_OFF;
  assign hit_mask = cfg_req.addr == AER_MASK_OFF;
  assign wr_stat  = cfg_req.valid & cfg_req.write & hit_stat;
  assign wr_mask  = cfg_req.valid & cfg_req.write & hit_mask;
  assign wr_bits  = cfg_req.data & aer_be_mask(cfg_req.be) & AER_IMPL;

  // Header word is pure wiring; writes to it fall through
  assign hdr_word = {AER_NEXT_PTR, AER_CAP_VER, AER_CAP_ID};

  assign stat_clr = wr_stat ? wr_bits : 32'h00000000;

  aer_w1c_bank #(
    .W    (32),
    .IMPL (AER_IMPL)
  ) u_status (
    .clk     (clk),
    .rst_n   (rst_n),
    .set_vec (evt_vec),
    .clr_vec (stat_clr),
    .q_ff    (status)
  );

  // Byte lanes not enabled keep their old mask value
  assign nxt_mask = wr_mask ?
                    ((mask_ff & ~(aer_be_mask(cfg_req.be) & AER_IMPL)) | wr_bits) :
                    mask_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ff <= AER_MASK_RST;
    end else begin
      mask_ff <= nxt_mask & AER_IMPL;
    end
  end

  aer_evt_gate #(
    .W (32)
  ) u_gate (
    .clk     (clk),
    .rst_n   (rst_n),
    .evt_vec (evt_vec),
    .mask    (mask_ff),
    .log_ff  (hdr_log_req_ff),
    .msg_ff  (err_msg_req_ff)
  );

  // Unmapped offsets read zero rather than stalling the completer
  assign rd_data = hit_hdr  ? hdr_word :
                   hit_stat ? status   :
                   hit_mask ? mask_ff  :
                   32'h00000000;

  assign nxt_rsp.valid = cfg_req.valid;
  assign nxt_rsp.data  = (cfg_req.valid & ~cfg_req.write) ? rd_data : 32'h00000000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rsp_ff  <= '0;
      stat_out_ff <= AER_STAT_RST;
    end else begin
      cfg_rsp_ff  <= nxt_rsp;
      stat_out_ff <= status;
    end
  end

  logic rd_hdr;
  logic rd_any;
  assign rd_hdr = cfg_req.valid & ~cfg_req.write & hit_hdr;
  assign rd_any = cfg_req.valid & ~cfg_req.write;

  a_hdr_read_const: assert property (@(posedge clk) disable iff (!rst_n)
    rd_hdr |=> cfg_rsp_ff.valid && cfg_rsp_ff.data == 32'h00010001)
    else $error("header word read wrong");

  a_hdr_write_noeff: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_req.valid && cfg_req.write && hit_hdr) ##[1:2] rd_hdr |=>
      cfg_rsp_ff.data[15:0] == AER_CAP_ID)
    else $error("header write took effect");

  a_evt_sets_stat: assert property (@(posedge clk) disable iff (!rst_n)
    evt_vec != 32'h00000000 |=> (status & $past(evt_vec)) == $past(evt_vec))
    else $error("event did not set status");

  a_w1c_clears: assert property (@(posedge clk) disable iff (!rst_n)
    wr_stat && ((wr_bits & ~evt_vec) != 32'h00000000) |=>
      (status & $past(wr_bits & ~evt_vec)) == 32'h00000000)
    else $error("write one did not clear status");

  a_stat_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_stat && evt_vec == 32'h00000000 |=> $stable(status))
    else $error("status changed without cause");

  a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rd_any && (hit_stat || hit_mask) |=> (cfg_rsp_ff.data & ~AER_IMPL) == 32'h00000000)
    else $error("reserved bit nonzero");

  a_rsvd_state_zero: assert property (@(posedge clk) disable iff (!rst_n)
    ((status | mask_ff) & ~AER_IMPL) == 32'h00000000)
    else $error("reserved state bit nonzero");

  a_mask_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_mask && cfg_req.be == 4'hF |=> mask_ff == ($past(cfg_req.data) & AER_IMPL))
    else $error("mask write lost");

  a_masked_no_log: assert property (@(posedge clk) disable iff (!rst_n)
    (evt_vec & mask_ff) != 32'h00000000 |=>
      (hdr_log_req_ff & $past(evt_vec & mask_ff)) == 32'h00000000)
    else $error("masked event was logged");

  a_masked_sets: assert property (@(posedge clk) disable iff (!rst_n)
    (evt_vec & mask_ff) != 32'h00000000 |=>
      (status & $past(evt_vec & mask_ff)) == $past(evt_vec & mask_ff))
    else $error("masked event lost from status");

  a_unmasked_msg: assert property (@(posedge clk) disable iff (!rst_n)
    (evt_vec & ~mask_ff) != 32'h00000000 |=> err_msg_req_ff &&
      ((hdr_log_req_ff & $past(evt_vec & ~mask_ff)) == $past(evt_vec & ~mask_ff)))
    else $error("unmasked event gave no message");

endmodule // aer_regs
`default_nettype wire

// ==== verif/aer_rc_model.sv ====
// Root complex side model issuing single configuration accesses
`timescale 1ns/1ns
`default_nettype none
module aer_rc_model (
  input  wire logic                  clk,
  input  wire aer_pkg::aer_cfg_rsp_s cfg_rsp_ff,
  output var  aer_pkg::aer_cfg_req_s cfg_req
);
  import aer_pkg::*;
  initial cfg_req = '0;
  // Released fields carry inverted junk and a zero be so stale values never look valid
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q, output logic ok);
    @(posedge clk);
    #1 cfg_req = '{valid: 1'b1, write: w, addr: a, be: be, data: d};
    @(posedge clk);
    #1 cfg_req = '{valid: 1'b0, write: ~w, addr: ~a, be: 4'h0, data: ~d};
    ok = 1'b0;
    q = 32'h0;
    for (int i = 0; i < 4; i++) begin
      if (cfg_rsp_ff.valid === 1'b1) begin
        ok = 1'b1;
        q = cfg_rsp_ff.data;
        break;
      end
      @(posedge clk);
      #1;
    end
  endtask
endmodule  // aer_rc_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking testbench for the uncorrectable error register block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import aer_pkg::*;
  logic         clk;
  logic         rst_n;
  aer_cfg_req_s cfg_req;
  aer_cfg_rsp_s cfg_rsp_ff;
  aer_evt_s     err_evt;
  logic [31:0]  hdr_log_req_ff;
  logic         err_msg_req_ff;
  logic [31:0]  stat_out_ff;
  int           failures;
  int           n_tests;
  int           pos [0:10] = '{0, 4, 12, 13, 14, 15, 16, 17, 18, 19, 20};

  aer_regs u_aer_regs (.clk(clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rsp_ff(cfg_rsp_ff),
    .err_evt(err_evt), .hdr_log_req_ff(hdr_log_req_ff), .err_msg_req_ff(err_msg_req_ff),
    .stat_out_ff(stat_out_ff));
  aer_rc_model u_aer_rc_model (.clk(clk), .cfg_rsp_ff(cfg_rsp_ff), .cfg_req(cfg_req));

  always #5 clk = ~clk;

  task automatic final_report();
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Writes answer with zero data, so every access is compared
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic [3:0] be = 4'hF);
    logic [31:0] q;
    logic        ok;
    u_aer_rc_model.xfer(w, a, d, be, q, ok);
    if (ok !== 1'b1) begin
      failures++;
      final_report();
    end
    chk(q, exp);
  endtask

  task automatic pulse(input logic [10:0] v);
    @(posedge clk);
    #1 err_evt = aer_evt_s'(v);
    @(posedge clk);
    #1 err_evt = '0;
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    err_evt = '0;
    failures = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    acc(1'b0, AER_HDR_OFF, 32'h0, 32'h00010001);
    acc(1'b0, AER_STAT_OFF, 32'h0, 32'h0);
    acc(1'b0, AER_MASK_OFF, 32'h0, 32'h0);
    acc(1'b1, AER_HDR_OFF, 32'hFFFFFFFF, 32'h0);
    acc(1'b0, AER_HDR_OFF, 32'h0, 32'h00010001);
    acc(1'b1, AER_MASK_OFF, 32'hFFFFFFFF, 32'h0);
    acc(1'b0, AER_MASK_OFF, 32'h0, 32'h001FF011);
    pulse(11'h7FF);
    chk(hdr_log_req_ff, 32'h0);
    chk({31'h0, err_msg_req_ff}, 32'h0);
    acc(1'b0, AER_STAT_OFF, 32'h0, 32'h001FF011);
    acc(1'b1, AER_STAT_OFF, 32'hFFFFFFFF, 32'h0);
    acc(1'b0, AER_STAT_OFF, 32'h0, 32'h0);
    acc(1'b1, AER_MASK_OFF, 32'h0, 32'h0);
    for (int k = 0; k < 11; k++) begin
      pulse(11'h001 << k);
      chk(hdr_log_req_ff, 32'h1 << pos[k]);
      chk({31'h0, err_msg_req_ff}, 32'h1);
      acc(1'b0, AER_STAT_OFF, 32'h0, 32'h1 << pos[k]);
      chk(stat_out_ff, 32'h1 << pos[k]);
      acc(1'b1, AER_STAT_OFF, 32'h1 << pos[k], 32'h0);
      acc(1'b0, AER_STAT_OFF, 32'h0, 32'h0);
    end
    // Only byte lane 2 enabled: bits 20:16 of the mask take the write
    acc(1'b1, AER_MASK_OFF, 32'hFFFFFFFF, 32'h0, 4'h4);
    acc(1'b0, AER_MASK_OFF, 32'h0, 32'h001F0000);
    acc(1'b0, 12'h10C, 32'h0, 32'h0);
    // Second reset in mid-run must drop sticky status
    pulse(11'h001);
    rst_n = 1'b0;
    @(posedge clk);
    #1 rst_n = 1'b1;
    acc(1'b0, AER_STAT_OFF, 32'h0, 32'h0);
    acc(1'b0, AER_MASK_OFF, 32'h0, 32'h0);
    final_report();
  end
endmodule  // tb_top
`default_nettype wire
